/* hdl/eth_irq_pins.sv */
// ethernet event flags, rx descriptor watermarks and phy pin selection
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module eth_irq_pins #(
  parameter bit PACKAGE_64 = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // dma and receive events, one-cycle pulses
  input wire logic tx_bus_error,
  input wire logic rx_bus_error,
  input wire logic rx_packet_done,
  input wire logic descriptor_buffer_count_inc,
  // interrupt request
  output logic irq,
  // mac transmit and management side
  input wire logic mac_mdc,
  input wire logic mac_mdio_o,
  input wire logic mac_mdio_oe,
  input wire logic mac_tx_en,
  input wire logic [3:0] mac_txd,
  input wire logic mac_tx_er,
  // mac receive side, synchronised; mii_active and alt_active are decoded from the config register
  output logic mac_mdio_i,
  output logic mac_rx_dv,
  output logic [3:0] mac_rxd,
  output logic mac_rx_er,
  output logic mac_crs,
  output logic mac_col,
  output logic mac_tx_clk_rise,
  output logic mac_rx_clk_rise,
  output logic mii_active,
  output logic alt_active,
  // default pin set
  input wire logic [10:0] dflt_pin_i,
  output logic [7:0] dflt_pin_o,
  output logic [7:0] dflt_pin_oe,
  output logic [10:0] dflt_in_claim,
  // alternate pin set
  input wire logic [10:0] alt_pin_i,
  output logic [7:0] alt_pin_o,
  output logic [7:0] alt_pin_oe,
  output logic [10:0] alt_in_claim
);
  mii_side_if side ();

  // register state
  logic tx_bus_error_flag_reg;
  logic rx_bus_error_flag_reg;
  logic empty_watermark_flag_reg;
  logic full_watermark_flag_reg;
  logic rx_packet_done_flag_reg;
  logic [7:0] empty_watermark_level_reg;
  logic [7:0] full_watermark_level_reg;
  logic [7:0] descriptor_buffer_count_reg;
  logic [31:0] irq_enable_reg;
  logic media_interface_select_reg;
  logic pin_set_select_reg;
  logic [31:0] rdata_reg;
  logic irq_reg;
  logic [7:0] core_o_reg;
  logic [7:0] core_oe_reg;
  logic [10:0] in_sync;
  logic txclk_prev_reg;
  logic rxclk_prev_reg;

  // address decode
  wire logic wr_flags = wr && (addr == eth_irq_pkg::FLAGS_OFS);
  wire logic wr_clr = wr && (addr == eth_irq_pkg::FLAGS_CLR_OFS);
  wire logic wr_set = wr && (addr == eth_irq_pkg::FLAGS_SET_OFS);
  wire logic wr_inv = wr && (addr == eth_irq_pkg::FLAGS_INV_OFS);
  wire logic wr_wmark = wr && (addr == eth_irq_pkg::WMARK_OFS);
  wire logic wr_ctrl1 = wr && (addr == eth_irq_pkg::CTRL1_OFS);
  wire logic wr_irq_en = wr && (addr == eth_irq_pkg::IRQ_EN_OFS);
  wire logic wr_config = wr && (addr == eth_irq_pkg::CONFIG_OFS);

  // software-writable flag: hardware set wins over any write
  function automatic logic sw_flag_next(input logic f, input logic ev,
    input logic wd, input logic w_dir, input logic w_clr,
    input logic w_set, input logic w_inv);
    logic n;
    n = f;
    if (w_dir) begin
      n = wd;
    end else if (w_clr) begin
      n = f & ~wd;
    end else if (w_set) begin
      n = f | wd;
    end else if (w_inv) begin
      n = f ^ wd;
    end
    return ev | n;
  endfunction : sw_flag_next

  wire logic tx_bus_error_flag_next = sw_flag_next(tx_bus_error_flag_reg,
    tx_bus_error, wdata[eth_irq_pkg::TX_BUS_ERR_BIT], wr_flags, wr_clr,
    wr_set, wr_inv);
  wire logic rx_bus_error_flag_next = sw_flag_next(rx_bus_error_flag_reg,
    rx_bus_error, wdata[eth_irq_pkg::RX_BUS_ERR_BIT], wr_flags, wr_clr,
    wr_set, wr_inv);
  wire logic rx_packet_done_flag_next = sw_flag_next(rx_packet_done_flag_reg,
    rx_packet_done, wdata[eth_irq_pkg::RX_DONE_BIT], wr_flags, wr_clr,
    wr_set, wr_inv);

  // descriptor buffer count; saturates so a stray pulse cannot wrap it
  wire logic dec_req = wr_ctrl1 && wdata[eth_irq_pkg::BUFFER_COUNT_DECREMENT_BIT];
  wire logic inc_ok = descriptor_buffer_count_inc &&
    (descriptor_buffer_count_reg != eth_irq_pkg::DESCRIPTOR_BUFFER_COUNT_MAX);
  wire logic dec_ok = dec_req && (descriptor_buffer_count_reg != 8'h00);
  wire logic [7:0] descriptor_buffer_count_next =
    (inc_ok && !dec_ok) ? descriptor_buffer_count_reg + 8'h01 :
    (dec_ok && !inc_ok) ? descriptor_buffer_count_reg - 8'h01 :
    descriptor_buffer_count_reg;

  // judged on the count as updated, so the step past a level clears
  wire logic empty_hit =
    descriptor_buffer_count_next <= empty_watermark_level_reg;
  wire logic full_hit =
    descriptor_buffer_count_next >= full_watermark_level_reg;
  wire logic empty_watermark_flag_next = empty_hit ? 1'b1 :
    (inc_ok ? 1'b0 : empty_watermark_flag_reg);
  wire logic full_watermark_flag_next = full_hit ? 1'b1 :
    (dec_ok ? 1'b0 : full_watermark_flag_reg);

  // assembled flag word; reserved bits read zero
  wire logic [31:0] flags_word = {17'h00000,
    tx_bus_error_flag_reg, rx_bus_error_flag_reg, 3'h0,
    empty_watermark_flag_reg, full_watermark_flag_reg,
    rx_packet_done_flag_reg, 7'h00};
  wire logic irq_next = |(flags_word & irq_enable_reg);

  wire logic [31:0] wmark_word = {8'h00, full_watermark_level_reg,
    8'h00, empty_watermark_level_reg};
  wire logic [31:0] status_word = {8'h00, descriptor_buffer_count_reg,
    14'h0000, alt_active, mii_active};
  wire logic [31:0] config_word = {30'h00000000, pin_set_select_reg,
    media_interface_select_reg};

  // read mux; aliases and control one read zero, unmapped reads zero
  wire logic [31:0] rd_mux =
    (addr == eth_irq_pkg::FLAGS_OFS) ? flags_word :
    (addr == eth_irq_pkg::WMARK_OFS) ? wmark_word :
    (addr == eth_irq_pkg::STATUS_OFS) ? status_word :
    (addr == eth_irq_pkg::IRQ_EN_OFS) ? irq_enable_reg :
    (addr == eth_irq_pkg::CONFIG_OFS) ? config_word : 32'h00000000;

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_bus_error_flag_reg <= 1'b0;
      rx_bus_error_flag_reg <= 1'b0;
      rx_packet_done_flag_reg <= 1'b0;
      empty_watermark_flag_reg <= 1'b0;
      full_watermark_flag_reg <= 1'b0;
    end else begin
      tx_bus_error_flag_reg <= tx_bus_error_flag_next;
      rx_bus_error_flag_reg <= rx_bus_error_flag_next;
      rx_packet_done_flag_reg <= rx_packet_done_flag_next;
      empty_watermark_flag_reg <= empty_watermark_flag_next;
      full_watermark_flag_reg <= full_watermark_flag_next;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      descriptor_buffer_count_reg <= eth_irq_pkg::DESCRIPTOR_BUFFER_COUNT_RST;
      empty_watermark_level_reg <= eth_irq_pkg::EMPTY_LVL_RST;
      full_watermark_level_reg <= eth_irq_pkg::FULL_LVL_RST;
    end else begin
      descriptor_buffer_count_reg <= descriptor_buffer_count_next;
      if (wr_wmark) begin
        empty_watermark_level_reg <=
          wdata[eth_irq_pkg::EMPTY_LVL_LSB +: 8];
        full_watermark_level_reg <= wdata[eth_irq_pkg::FULL_LVL_LSB +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_enable_reg <= eth_irq_pkg::IRQ_EN_RST;
      media_interface_select_reg <= eth_irq_pkg::MEDIA_SEL_RST;
      pin_set_select_reg <= eth_irq_pkg::PIN_SET_RST;
    end else begin
      if (wr_irq_en) begin
        irq_enable_reg <= wdata;
      end
      if (wr_config) begin
        media_interface_select_reg <= wdata[eth_irq_pkg::MEDIA_SEL_BIT];
        pin_set_select_reg <= wdata[eth_irq_pkg::PIN_SET_BIT];
      end
    end
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= 32'h00000000;
      irq_reg <= 1'b0;
    end else begin
      rdata_reg <= rd ? rd_mux : 32'h00000000;
      irq_reg <= irq_next;
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;

  // mode selection; the small package has no alternate mii, so that
  // request falls back to the default pin set
  wire logic alt_req = !pin_set_select_reg;
  wire logic alt_blocked = PACKAGE_64 && media_interface_select_reg;
  assign mii_active = media_interface_select_reg;
  assign alt_active = alt_req && !alt_blocked;
  assign side.mii_mode = mii_active;
  assign side.alt_set = alt_active;

  // pin outputs registered so the pads see no decode glitches
  always_ff @(posedge clk) begin
    if (reset) begin
      core_o_reg <= 8'h00;
      core_oe_reg <= 8'h00;
    end else begin
      core_o_reg <= {mac_tx_er, mac_txd, mac_tx_en, mac_mdio_o, mac_mdc};
      core_oe_reg <= {5'h1f, mac_mdio_oe, 2'h3};
    end
  end
  assign side.core_o = core_o_reg;
  assign side.core_oe = core_oe_reg;

  pin_select u_pin_select (
    .side(side.mux),
    .dflt_pin_i(dflt_pin_i),
    .dflt_pin_o(dflt_pin_o),
    .dflt_pin_oe(dflt_pin_oe),
    .dflt_in_claim(dflt_in_claim),
    .alt_pin_i(alt_pin_i),
    .alt_pin_o(alt_pin_o),
    .alt_pin_oe(alt_pin_oe),
    .alt_in_claim(alt_in_claim)
  );

  // phy inputs come from outside the clock domain
  pin_sync #(.WIDTH(11)) u_in_sync (
    .clk(clk),
    .reset(reset),
    .async_in(side.sel_i),
    .sync_out(in_sync)
  );

  // media clock edges found by sampling; rmii reference sits on rx clock
  always_ff @(posedge clk) begin
    if (reset) begin
      txclk_prev_reg <= 1'b0;
      rxclk_prev_reg <= 1'b0;
    end else begin
      txclk_prev_reg <= in_sync[eth_irq_pkg::PI_TXCLK];
      rxclk_prev_reg <= in_sync[eth_irq_pkg::PI_RXCLK];
    end
  end
  wire logic txclk_rise = in_sync[eth_irq_pkg::PI_TXCLK] && !txclk_prev_reg;
  wire logic rxclk_rise = in_sync[eth_irq_pkg::PI_RXCLK] && !rxclk_prev_reg;
  assign mac_tx_clk_rise = mii_active ? txclk_rise : rxclk_rise;
  assign mac_rx_clk_rise = rxclk_rise;

  // receive fields; rmii carries two data bits and a combined crs/dv
  assign mac_mdio_i = in_sync[eth_irq_pkg::PI_MDIO];
  assign mac_rx_dv = mii_active ? in_sync[eth_irq_pkg::PI_RXDV]
                                : in_sync[eth_irq_pkg::PI_CRS];
  assign mac_rxd = in_sync[eth_irq_pkg::PI_RXD0 +: 4];
  assign mac_rx_er = in_sync[eth_irq_pkg::PI_RXER];
  assign mac_crs = in_sync[eth_irq_pkg::PI_CRS];
  assign mac_col = in_sync[eth_irq_pkg::PI_COL];
endmodule : eth_irq_pins

/* hdl/eth_irq_pkg.sv */
// constants shared by the event-flag and pin-select logic
package eth_irq_pkg;
  // register byte offsets
  localparam logic [7:0] FLAGS_OFS = 8'h00;
  localparam logic [7:0] FLAGS_CLR_OFS = 8'h04;
  localparam logic [7:0] FLAGS_SET_OFS = 8'h08;
  localparam logic [7:0] FLAGS_INV_OFS = 8'h0c;
  localparam logic [7:0] WMARK_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] CTRL1_OFS = 8'h18;
  localparam logic [7:0] IRQ_EN_OFS = 8'h1c;
  localparam logic [7:0] CONFIG_OFS = 8'h20;
  // event flag bit positions
  localparam int TX_BUS_ERR_BIT = 14;
  localparam int RX_BUS_ERR_BIT = 13;
  localparam int EMPTY_WM_BIT = 9;
  localparam int FULL_WM_BIT = 8;
  localparam int RX_DONE_BIT = 7;
  // watermark, status, control and config fields
  localparam int EMPTY_LVL_LSB = 0;
  localparam int FULL_LVL_LSB = 16;
  localparam int DESCRIPTOR_BUFFER_COUNT_LSB = 16;
  localparam int STAT_MII_BIT = 0;
  localparam int STAT_ALT_BIT = 1;
  localparam int BUFFER_COUNT_DECREMENT_BIT = 0;
  localparam int MEDIA_SEL_BIT = 0;
  localparam int PIN_SET_BIT = 1;
  // reset values
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [7:0] EMPTY_LVL_RST = 8'h00;
  localparam logic [7:0] FULL_LVL_RST = 8'hff;
  localparam logic [7:0] DESCRIPTOR_BUFFER_COUNT_RST = 8'h00;
  localparam logic [31:0] IRQ_EN_RST = 32'h0000_0000;
  localparam logic MEDIA_SEL_RST = 1'b1;
  localparam logic PIN_SET_RST = 1'b1;
  localparam logic [7:0] DESCRIPTOR_BUFFER_COUNT_MAX = 8'hff;
  // pin-side output vector: mdc, mdio, tx_en, txd0..3, tx_er
  localparam int PO_MDC = 0;
  localparam int PO_MDIO = 1;
  localparam int PO_TXEN = 2;
  localparam int PO_TXD0 = 3;
  localparam int PO_TXER = 7;
  localparam logic [7:0] MII_OUT_MASK = 8'hff;
  localparam logic [7:0] RMII_OUT_MASK = 8'h1f;
  // pin-side input vector
  localparam int PI_MDIO = 0;
  localparam int PI_TXCLK = 1;
  localparam int PI_RXCLK = 2;
  localparam int PI_RXDV = 3;
  localparam int PI_RXD0 = 4;
  localparam int PI_RXER = 8;
  localparam int PI_CRS = 9;
  localparam int PI_COL = 10;
  localparam logic [10:0] MII_IN_MASK = 11'h7ff;
  localparam logic [10:0] RMII_IN_MASK = 11'h335;
endpackage : eth_irq_pkg

/* hdl/mii_side_if.sv */
// mac-side signals between the flag/config core and the pin selector
`timescale 1ns/1ps
interface mii_side_if;
  logic mii_mode;
  logic alt_set;
  logic [7:0] core_o;
  logic [7:0] core_oe;
  logic [10:0] sel_i;
  modport core (output mii_mode, output alt_set, output core_o,
    output core_oe, input sel_i);
  modport mux (input mii_mode, input alt_set, input core_o,
    input core_oe, output sel_i);
endinterface : mii_side_if

/* hdl/pin_select.sv */
// routes the mac signals to the default or alternate ethernet pin set
`timescale 1ns/1ps
module pin_select (
  // mac side
  mii_side_if.mux side,
  // default pin set
  input wire logic [10:0] dflt_pin_i,
  output logic [7:0] dflt_pin_o,
  output logic [7:0] dflt_pin_oe,
  output logic [10:0] dflt_in_claim,
  // alternate pin set
  input wire logic [10:0] alt_pin_i,
  output logic [7:0] alt_pin_o,
  output logic [7:0] alt_pin_oe,
  output logic [10:0] alt_in_claim
);
  wire logic [7:0] out_mask;
  wire logic [10:0] in_mask;
  // mii uses every pin, rmii only its reduced set
  assign out_mask = side.mii_mode ? eth_irq_pkg::MII_OUT_MASK
                                  : eth_irq_pkg::RMII_OUT_MASK;
  assign in_mask = side.mii_mode ? eth_irq_pkg::MII_IN_MASK
                                 : eth_irq_pkg::RMII_IN_MASK;
  // unused or unselected pins: no drive, no claim, so others may own them
  assign dflt_pin_o = side.alt_set ? 8'h00 : side.core_o & out_mask;
  assign dflt_pin_oe = side.alt_set ? 8'h00
                                    : side.core_oe & out_mask;
  assign dflt_in_claim = side.alt_set ? 11'h000 : in_mask;
  assign alt_pin_o = side.alt_set ? side.core_o & out_mask : 8'h00;
  assign alt_pin_oe = side.alt_set ? side.core_oe & out_mask
                                   : 8'h00;
  assign alt_in_claim = side.alt_set ? in_mask : 11'h000;
  // unclaimed inputs read as zero toward the mac
  assign side.sel_i = (side.alt_set ? alt_pin_i : dflt_pin_i) & in_mask;
endmodule : pin_select

/* hdl/pin_sync.sv */
// two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pin_sync

/* verif/eth_irq_pins_chk.sv */
// port assertions for the event-flag and pin-select block
`timescale 1ns/1ps
module eth_irq_pins_chk #(
  parameter bit PACKAGE_64 = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port and events
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic tx_bus_error,
  input wire logic rx_bus_error,
  input wire logic rx_packet_done,
  // mac side
  input wire logic mac_tx_en,
  input wire logic mac_rx_clk_rise,
  input wire logic mii_active,
  input wire logic alt_active,
  // pin sets
  input wire logic [7:0] dflt_pin_o,
  input wire logic [7:0] dflt_pin_oe,
  input wire logic [7:0] alt_pin_oe,
  input wire logic [10:0] dflt_in_claim,
  input wire logic [10:0] alt_in_claim
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire flag_rd = rd && addr == eth_irq_pkg::FLAGS_OFS;
  wire [7:0] oe_any = dflt_pin_oe | alt_pin_oe;
  wire [10:0] cl_any = dflt_in_claim | alt_in_claim;
  property p_txe;
    tx_bus_error ##1 flag_rd |=> rdata[14];
  endproperty
  a_txe: assert property (p_txe) else $error("tx bus error not flagged");
  property p_rxe;
    rx_bus_error ##1 flag_rd |=> rdata[13];
  endproperty
  a_rxe: assert property (p_rxe) else $error("rx bus error not flagged");
  property p_done;
    rx_packet_done ##1 flag_rd |=> rdata[7];
  endproperty
  a_done: assert property (p_done) else $error("rx done not flagged");
  property p_rdata;
    !$past(rd) |-> rdata == 32'h0;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  property p_alt_off;
    !alt_active |-> alt_pin_oe == 8'h00 && alt_in_claim == 11'h000;
  endproperty
  a_alt_off: assert property (p_alt_off) else $error("alt set busy");
  property p_dflt_off;
    alt_active |-> dflt_pin_oe == 8'h00 && dflt_in_claim == 11'h000;
  endproperty
  a_dflt_off: assert property (p_dflt_off) else $error("dflt set busy");
  property p_rmii_oe;
    !mii_active |-> (oe_any & ~eth_irq_pkg::RMII_OUT_MASK) == 8'h00;
  endproperty
  a_rmii_oe: assert property (p_rmii_oe) else $error("rmii oe");
  property p_claim;
    cl_any == (mii_active ? eth_irq_pkg::MII_IN_MASK
                          : eth_irq_pkg::RMII_IN_MASK);
  endproperty
  a_claim: assert property (p_claim) else $error("input claims");
  property p_pkg;
    alt_active && mii_active |-> !PACKAGE_64;
  endproperty
  a_pkg: assert property (p_pkg) else $error("alt mii on small pkg");
  property p_txen;
    // the pin register holds zero through reset
    !alt_active && !$past(reset) |->
      dflt_pin_o[eth_irq_pkg::PO_TXEN] == $past(mac_tx_en);
  endproperty
  a_txen: assert property (p_txen) else $error("tx enable path");
  property p_rise;
    mac_rx_clk_rise |=> !mac_rx_clk_rise;
  endproperty
  a_rise: assert property (p_rise) else $error("clock rise not a pulse");
  c_txe: cover property (tx_bus_error ##1 flag_rd);
  c_alt: cover property (alt_active && !mii_active);
  c_rise: cover property (mac_rx_clk_rise);
endmodule : eth_irq_pins_chk
bind eth_irq_pins eth_irq_pins_chk #(.PACKAGE_64(PACKAGE_64)) chk (.*);

/* verif/eth_irq_pins_test.sv */
// self-checking bench for the ethernet flag and pin-select block
`timescale 1ns/1ps
module eth_irq_pins_test;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] ev = 4'h0;
  logic mac_tx_en = 1'b0;
  logic [3:0] mac_txd = 4'h0;
  logic frame = 1'b0;
  logic use_alt = 1'b0;
  logic [31:0] rdata;
  logic irq, mac_mdio_i, mac_rx_dv, mac_rx_er, mac_crs, mac_col;
  logic mac_tx_clk_rise, mac_rx_clk_rise, mii_active, alt_active;
  logic [3:0] mac_rxd;
  logic [10:0] dflt_pin_i, alt_pin_i, dflt_in_claim, alt_in_claim;
  logic [7:0] dflt_pin_o, dflt_pin_oe, alt_pin_o, alt_pin_oe;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_rise;
  // rows: pin set bit, interface bit, expected alt, expected mii
  localparam logic [3:0] ROWS [4] = '{4'hd, 4'h7, 4'h8, 4'h2};
  eth_irq_pins dut (.mac_mdc(1'b0), .mac_mdio_o(1'b0),
    .mac_mdio_oe(1'b1), .mac_tx_er(1'b0), .tx_bus_error(ev[0]),
    .rx_bus_error(ev[1]), .rx_packet_done(ev[2]), .descriptor_buffer_count_inc(ev[3]), .*);
  logic alt_small, mii_small;
  // small package: alternate mii must fall back to the default pins
  eth_irq_pins #(.PACKAGE_64(1'b1)) dut_small (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(),
    .tx_bus_error(1'b0), .rx_bus_error(1'b0), .rx_packet_done(1'b0),
    .descriptor_buffer_count_inc(1'b0), .irq(), .mac_mdc(1'b0), .mac_mdio_o(1'b0),
    .mac_mdio_oe(1'b1), .mac_tx_en(mac_tx_en), .mac_txd(mac_txd),
    .mac_tx_er(1'b0), .mac_mdio_i(), .mac_rx_dv(), .mac_rxd(),
    .mac_rx_er(), .mac_crs(), .mac_col(), .mac_tx_clk_rise(),
    .mac_rx_clk_rise(), .mii_active(mii_small), .alt_active(alt_small),
    .dflt_pin_i(dflt_pin_i), .dflt_pin_o(), .dflt_pin_oe(),
    .dflt_in_claim(), .alt_pin_i(alt_pin_i), .alt_pin_o(),
    .alt_pin_oe(), .alt_in_claim());
  phy_model phy (.frame(frame), .use_alt(use_alt), .nib(4'ha),
    .dflt_pins(dflt_pin_i), .alt_pins(alt_pin_i));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task chk_irq(input logic e);
    @(negedge clk);
    chk(irq, e);
    @(posedge clk);
  endtask : chk_irq
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task rd_reg(input logic [7:0] a, input logic [31:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
  endtask : rd_reg
  task pulse(input logic [3:0] v);
    ev <= v;
    @(posedge clk);
    ev <= 4'h0;
    @(posedge clk);
  endtask : pulse
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    frame <= 1'b1;
    mac_tx_en <= 1'b1;
    mac_txd <= 4'h5;
    for (int i = 0; i < 4; i++) begin
      wr_reg(eth_irq_pkg::CONFIG_OFS, {30'h0, ROWS[i][3:2]});
      use_alt <= ROWS[i][1];
      n_rise = 0;
      repeat (4) @(posedge clk);
      repeat (16) begin
        @(negedge clk);
        n_rise += mac_rx_clk_rise;
      end
      chk(n_rise, 2);
      chk(mac_rxd, ROWS[i][0] ? 4'ha : 4'h2);
      chk(mac_rx_dv, 1'b1);
      chk(ROWS[i][1] ? dflt_in_claim : alt_in_claim, 11'h0);
      chk(ROWS[i][1] ? alt_pin_oe : dflt_pin_oe,
        ROWS[i][0] ? 8'hff : 8'h1f);
      chk((ROWS[i][1] ? alt_pin_o : dflt_pin_o) & (ROWS[i][0] ? 8'hff
        : 8'h1f), ROWS[i][0] ? 8'h2c : 8'h0c);
      @(posedge clk);
      rd_reg(eth_irq_pkg::STATUS_OFS, {30'h0, ROWS[i][1:0]});
      chk(alt_small, ROWS[i][1] && !ROWS[i][0]);
      chk(mii_small, ROWS[i][0]);
    end
    $display("pin modes done");
    frame <= 1'b0;
    use_alt <= 1'b0;
    wr_reg(eth_irq_pkg::WMARK_OFS, 32'h0004_0002);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_0200);
    rd_reg(eth_irq_pkg::WMARK_OFS, 32'h00ff_0000);
    rd_reg(eth_irq_pkg::IRQ_EN_OFS, 32'h0);
    rd_reg(eth_irq_pkg::STATUS_OFS, 32'h1);
    rd_reg(eth_irq_pkg::CONFIG_OFS, 32'h3);
    rd_reg(8'h40, 32'h0);
    $display("reset done");
    wr_reg(eth_irq_pkg::IRQ_EN_OFS, 32'h0000_6080);
    pulse(4'h1);
    pulse(4'h2);
    pulse(4'h4);
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_6280);
    chk_irq(1'b1);
    wr_reg(eth_irq_pkg::FLAGS_CLR_OFS, 32'h300);
    wr_reg(eth_irq_pkg::FLAGS_SET_OFS, 32'h300);
    wr_reg(eth_irq_pkg::FLAGS_INV_OFS, 32'h300);
    // direct write keeps the sticky bits; only 9 and 8 are in question
    wr_reg(eth_irq_pkg::FLAGS_OFS, 32'h6180);
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_6280);
    wr_reg(eth_irq_pkg::FLAGS_CLR_OFS, 32'h4000);
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_2280);
    chk_irq(1'b1);
    wr_reg(eth_irq_pkg::FLAGS_CLR_OFS, 32'h2080);
    repeat (2) @(posedge clk);
    chk_irq(1'b0);
    // clear in the same cycle as a new error: the error must stick
    ev <= 4'h1;
    wr <= 1'b1;
    addr <= eth_irq_pkg::FLAGS_CLR_OFS;
    wdata <= 32'h4000;
    @(posedge clk);
    ev <= 4'h0;
    wr <= 1'b0;
    @(posedge clk);
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_4200);
    // events read back in the very next cycle
    ev <= 4'h7;
    @(posedge clk);
    ev <= 4'h0;
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_6280);
    wr_reg(eth_irq_pkg::FLAGS_CLR_OFS, 32'h2080);
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_4200);
    $display("events done");
    wr_reg(eth_irq_pkg::WMARK_OFS, 32'h0004_0002);
    repeat (3) pulse(4'h8);
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_4000);
    pulse(4'h8);
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_4100);
    pulse(4'h8);
    wr_reg(eth_irq_pkg::STATUS_OFS, 32'h0);
    rd_reg(eth_irq_pkg::STATUS_OFS, 32'h0005_0001);
    wr_reg(eth_irq_pkg::CTRL1_OFS, 32'h1);
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_4100);
    wr_reg(eth_irq_pkg::CTRL1_OFS, 32'h1);
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_4000);
    rd_reg(eth_irq_pkg::STATUS_OFS, 32'h0003_0001);
    wr_reg(eth_irq_pkg::CTRL1_OFS, 32'h1);
    rd_reg(eth_irq_pkg::FLAGS_OFS, 32'h0000_4200);
    $display("watermarks done");
    test_done;
  end
endmodule : eth_irq_pins_test

/* verif/phy_model.sv */
// phy model: receive-side pin levels on the selected pin set
`timescale 1ns/1ps
module phy_model (
  // control from the bench
  input wire logic frame,
  input wire logic use_alt,
  input wire logic [3:0] nib,
  // pin sets
  output logic [10:0] dflt_pins,
  output logic [10:0] alt_pins
);
  logic rclk = 1'b0;
  logic noise = 1'b0;
  logic [10:0] pv;
  // media clock stands still between frames; offset keeps it off clk
  initial begin
    #7;
    forever #100 rclk = frame ? ~rclk : 1'b0;
  end
  always #25 noise = ~noise;
  // mdio idles high through its pull-up
  assign pv = {1'b0, frame, 1'b0, nib, frame, rclk, rclk, 1'b1};
  // the unused set shows a changing pattern, never a stale level
  assign dflt_pins = use_alt ? {11{noise}} : pv;
  assign alt_pins = use_alt ? pv : {11{noise}};
endmodule : phy_model
